/* design/level_sync.v */
// Two-stage synchroniser for asynchronous level inputs.
`timescale 1ns/1ps
`default_nettype none
module level_sync #(
    parameter WIDTH = 1
) (
    input wire sys_clk, // Core clock.
    input wire reset, // Synchronous reset, active high.
    input wire [WIDTH-1:0] async_in, // Asynchronous levels.
    output reg [WIDTH-1:0] sync_out // Synchronised levels.
);
    reg [WIDTH-1:0] meta;

    always @(posedge sys_clk) begin
        if (reset) begin
            meta <= {WIDTH{1'b0}};
            sync_out <= {WIDTH{1'b0}};
        end else begin
            meta <= async_in;
            sync_out <= meta;
        end
    end
endmodule // level_sync
`default_nettype wire

/* design/page_memory.v */
// Byte-wide page memory with synchronous write and registered read data.
`timescale 1ns/1ps
`default_nettype none
module page_memory #(
    parameter ADDR_W = 7
) (
    input wire sys_clk, // Core clock.
    input wire we, // Write strobe.
    input wire [ADDR_W-1:0] addr, // Byte address.
    input wire [7:0] wdata, // Write data.
    output reg [7:0] rdata // Read data, one cycle after the address.
);
    reg [7:0] mem [0:(1<<ADDR_W)-1];
    integer i;

    // Contents start cleared so a fresh part boots with zeroed configuration.
    initial begin
        for (i = 0; i < (1<<ADDR_W); i = i + 1) begin
            mem[i] = 8'h00;
        end
        rdata = 8'h00;
    end

    always @(posedge sys_clk) begin
        if (we) begin
            mem[addr] <= wdata;
        end
        rdata <= mem[addr];
    end
endmodule // page_memory
`default_nettype wire

/* design/supply_monitor_scan_boot_core.v */
// Boot copy, page selection, enable logic and monitor scan of the supply manager core.
`timescale 1ns/1ps
`default_nettype none
`include "supply_core_regs.vh"
// Functional notes
// - After boot, with enable high and disable bit 0, scan all enabled inputs.
// - Each stop converts 10 bits, stores it, compares within 8.3 us bound.
// - Violations fault only when enabled; enabled faults may trigger the write-protected logger.
// - Power-on clear zeroes all volatile registers including trim codes 00h-0Bh.
// - Boot lasts at most 1.5 ms; faults masked, nonvolatile contents loaded.
// - Boot copies nonvolatile 0Fh-7Dh into the same default-page offsets.
// - No serial response during boot; host waits until boot ends.
// - Reset output low in boot, released after timeout once no flag is set; only inputs with a sequence position and range not 11 can be flagged.
// - During boot, gpio, trim and sequenced outputs are high impedance.
// - Three pages: default, extended, nonvolatile; default selected after reset.
// - Nonvolatile offsets 00h-0Eh hold the saved fault record.
// - 98h or 09h select extended page; 99h or 0Ah return to default.
// - 9Ah or 0Bh select nonvolatile page; 9Bh or 0Ch return to default.
// - Run only while enable high and disable bit 0; otherwise stop.
// - Fault during power-up turns all sequenced outputs off at once.
// - Latch-off fault persists until enable or disable bit toggles.
// - Control bits: 0 disable, 1 margin, 2 early warning polarity, 3 watchdog.
// - Range code 11 inputs are skipped, never converted, never fault.
// - Thresholds are 8 bits, compared with upper 8 result bits.
// - Results sit at extended offsets 00h-17h, readable by the host.
// - Threshold checks apply only to inputs assigned a sequence position.
// - Two-bit range field per input, four per byte.
// - Result uses two bytes: upper eight, then low two in bits 7:6.
// - Disabled inputs keep their last converted result.
module supply_monitor_scan_boot_core #(
    parameter [16:0] BOOT_MAX_CYC = `BOOT_MAX_CYC,
    parameter [15:0] RESET_HOLD_CYC = `RESET_HOLD_CYC
) (
    input wire sys_clk, // Core clock, 40 MHz.
    input wire reset, // Power-on clear, synchronous, active high.
    input wire en_pin, // Enable pin, asynchronous level.
    input wire acc_valid, // Register access request from the serial front end.
    input wire acc_write, // 1 = write, 0 = read.
    input wire [7:0] acc_addr, // Offset within the selected page.
    input wire [7:0] acc_wdata, // Write data.
    output wire acc_ready, // Request taken when high with acc_valid.
    output reg [7:0] acc_rdata, // Read data.
    output reg acc_rvalid, // Read data valid, one-cycle pulse.
    input wire page_cmd_valid, // Page command strobe.
    input wire page_cmd_jtag, // Command came over JTAG (1) or I2C (0).
    input wire [7:0] page_cmd_code, // Page command code.
    output reg [1:0] page_sel, // Currently selected page.
    output reg [3:0] adc_channel, // Monitor input selected by the multiplexer.
    output reg adc_start, // Conversion start pulse.
    input wire adc_done, // Conversion done pulse.
    input wire [9:0] adc_result, // Conversion result, valid with adc_done.
    output reg boot_busy, // Boot sequence in progress.
    output reg monitor_run, // Sequencing and monitoring active.
    output reg reset_out_n, // Reset output, active low.
    output reg fault_out, // An enabled fault is present.
    output reg [11:0] seq_out, // Sequenced outputs.
    output reg [11:0] seq_oe, // Sequenced output enables.
    output reg [11:0] trim_oe, // Trim output enables.
    output reg [5:0] gpio_oe // General-purpose pin enables.
);
    localparam [4:0] S_IDLE = 5'b00001;
    localparam [4:0] S_PICK = 5'b00010;
    localparam [4:0] S_CONV = 5'b00100;
    localparam [4:0] S_CMP = 5'b01000;
    localparam [4:0] S_WAIT = 5'b10000;
    localparam [15:0] CONV_MAX = `CONV_MAX_CYC;

    wire en_sync;
    wire run;
    wire acc_fire;
    wire [7:0] dp_rdata;
    wire [7:0] nv_rdata;
    wire dp_we;
    wire [6:0] dp_addr;
    wire [7:0] dp_wdata;
    wire [7:0] boot_data;
    reg nv_we;
    reg [7:0] nv_addr;
    reg [7:0] nv_wdata;
    wire [119:0] res_flat;
    wire [11:0] viol;
    wire [11:0] monitored;
    wire fault_now;
    reg booting;
    reg [6:0] boot_idx;
    reg boot_wr;
    reg [6:0] boot_wr_addr;
    reg [16:0] boot_cnt;
    reg [7:0] ctrl;
    reg [7:0] fault_mode;
    reg [23:0] range_bits;
    reg [11:0] fault_en;
    reg [11:0] log_en;
    reg [11:0] seq_asg;
    reg [11:0] flags;
    reg [11:0] trim_en;
    reg [5:0] gpio_dir;
    reg [4:0] state;
    reg [15:0] conv_cnt;
    reg res_we;
    reg [9:0] res_data;
    reg fault_latched;
    reg [15:0] hold_cnt;
    reg logging;
    reg log_lock;
    reg [3:0] log_idx;
    reg rd_pend;
    reg [1:0] rd_page;
    reg [7:0] rd_addr;
    reg [7:0] ext_byte;
    reg [7:0] next_rdata;

    level_sync #(.WIDTH(1)) u_en_sync (
        .sys_clk(sys_clk),
        .reset(reset),
        .async_in(en_pin),
        .sync_out(en_sync)
    );

    page_memory #(.ADDR_W(7)) u_default_page (
        .sys_clk(sys_clk),
        .we(dp_we),
        .addr(dp_addr),
        .wdata(dp_wdata),
        .rdata(dp_rdata)
    );

    page_memory #(.ADDR_W(8)) u_nonvol_page (
        .sys_clk(sys_clk),
        .we(nv_we),
        .addr(nv_addr),
        .wdata(nv_wdata),
        .rdata(nv_rdata)
    );

    assign run = ~booting & en_sync & ~ctrl[`CTRL_SW_DISABLE];
    assign acc_ready = ~booting & ~boot_busy & ~logging;
    assign acc_fire = acc_valid & acc_ready;

    // Boot walks 00h-7Dh once: the low offsets are cleared, the rest copied.
    always @(posedge sys_clk) begin
        if (reset) begin
            booting <= 1'b1;
            boot_idx <= 7'h00;
            boot_wr <= 1'b0;
            boot_wr_addr <= 7'h00;
            boot_cnt <= 17'h00000;
        end else if (booting) begin
            boot_cnt <= boot_cnt + 17'h00001;
            boot_wr <= (boot_idx <= `DP_COPY_LAST);
            boot_wr_addr <= boot_idx;
            if (boot_idx <= `DP_COPY_LAST) begin
                boot_idx <= boot_idx + 7'h01;
            end
            if ((boot_wr && boot_wr_addr == `DP_COPY_LAST) ||
                boot_cnt == BOOT_MAX_CYC - 17'h00001) begin
                booting <= 1'b0;
            end
        end else begin
            boot_wr <= 1'b0;
        end
    end

    assign boot_data = (boot_wr_addr < `DP_COPY_FIRST) ? `RESET_BYTE : nv_rdata;
    assign dp_we = boot_wr | (acc_fire & acc_write & page_sel == `PAGE_DEFAULT & ~acc_addr[7]);
    assign dp_addr = booting ? boot_wr_addr : acc_addr[6:0];
    assign dp_wdata = booting ? boot_data : acc_wdata;

    // The logger owns the nonvolatile port while it runs; host access waits on acc_ready.
    always @* begin
        nv_we = 1'b0;
        nv_addr = acc_addr;
        nv_wdata = acc_wdata;
        if (booting) begin
            nv_addr = {1'b0, boot_idx};
        end else if (logging) begin
            nv_we = 1'b1;
            nv_addr = {4'h0, log_idx};
            if (log_idx < `NV_LOG_FLAGS_LO) begin
                nv_wdata = res_flat[log_idx*10+2 +: 8];
            end else if (log_idx == `NV_LOG_FLAGS_LO) begin
                nv_wdata = flags[7:0];
            end else if (log_idx == `NV_LOG_FLAGS_HI) begin
                nv_wdata = {4'h0, flags[11:8]};
            end else begin
                nv_wdata = `NV_LOG_MARK;
            end
        end else begin
            nv_we = acc_fire & acc_write & page_sel == `PAGE_NONVOL &
                ~(log_lock & acc_addr <= `NV_LOG_LAST);
        end
    end

    always @(posedge sys_clk) begin
        if (reset) begin
            page_sel <= `PAGE_DEFAULT;
        end else if (page_cmd_valid && !booting) begin
            case ({page_cmd_jtag, page_cmd_code})
                {1'b0, `CMD_I2C_EXT_ON}, {1'b1, `CMD_JTAG_EXT_ON}: page_sel <= `PAGE_EXTENDED;
                {1'b0, `CMD_I2C_EXT_OFF}, {1'b1, `CMD_JTAG_EXT_OFF}: page_sel <= `PAGE_DEFAULT;
                {1'b0, `CMD_I2C_NV_ON}, {1'b1, `CMD_JTAG_NV_ON}: page_sel <= `PAGE_NONVOL;
                {1'b0, `CMD_I2C_NV_OFF}, {1'b1, `CMD_JTAG_NV_OFF}: page_sel <= `PAGE_DEFAULT;
                default: page_sel <= page_sel;
            endcase
        end
    end

    // Shadow copies of the default-page bytes that steer the scan, loaded by boot or host.
    always @(posedge sys_clk) begin
        if (reset) begin
            ctrl <= 8'h00;
            fault_mode <= 8'h00;
            range_bits <= 24'h000000;
            fault_en <= 12'h000;
            log_en <= 12'h000;
            seq_asg <= 12'h000;
        end else if (dp_we) begin
            case (dp_addr)
                `DP_ENABLE_MARGIN_CONTROL: ctrl <= {4'h0, dp_wdata[3:0]};
                `DP_FAULT_MODE: fault_mode <= dp_wdata;
                `DP_RANGE0: range_bits[7:0] <= dp_wdata;
                `DP_RANGE1: range_bits[15:8] <= dp_wdata;
                `DP_RANGE2: range_bits[23:16] <= dp_wdata;
                `DP_FAULT_EN_LO: fault_en[7:0] <= dp_wdata;
                `DP_FAULT_EN_HI: fault_en[11:8] <= dp_wdata[3:0];
                `DP_LOG_EN_LO: log_en[7:0] <= dp_wdata;
                `DP_LOG_EN_HI: log_en[11:8] <= dp_wdata[3:0];
                `DP_SEQ_ASSIGN_LO: seq_asg[7:0] <= dp_wdata;
                `DP_SEQ_ASSIGN_HI: seq_asg[11:8] <= dp_wdata[3:0];
                default: ctrl <= ctrl;
            endcase
        end
    end

    genvar g;
    generate
        for (g = 0; g < 12; g = g + 1) begin : gen_ch
            localparam [6:0] CH = g;
            reg [7:0] ov;
            reg [7:0] uv;
            reg [9:0] result;
            always @(posedge sys_clk) begin
                if (reset) begin
                    ov <= 8'h00;
                    uv <= 8'h00;
                    result <= 10'h000;
                end else begin
                    if (dp_we && dp_addr == `DP_OV_BASE + CH) begin
                        ov <= dp_wdata;
                    end
                    if (dp_we && dp_addr == `DP_UV_BASE + CH) begin
                        uv <= dp_wdata;
                    end
                    if (res_we && adc_channel == CH[3:0]) begin
                        result <= res_data;
                    end
                end
            end
            assign res_flat[g*10 +: 10] = result;
            assign monitored[g] = (range_bits[2*g +: 2] != `RANGE_OFF) & seq_asg[g];
            assign viol[g] = (result[9:2] > ov) | (result[9:2] < uv);
        end
    endgenerate

    assign fault_now = |(flags & fault_en);

    always @(posedge sys_clk) begin
        if (reset) begin
            state <= S_IDLE;
            adc_channel <= 4'h0;
            adc_start <= 1'b0;
            conv_cnt <= 16'h0000;
            res_we <= 1'b0;
            res_data <= 10'h000;
            flags <= 12'h000;
        end else begin
            adc_start <= 1'b0;
            res_we <= 1'b0;
            if (!run) begin
                state <= S_IDLE;
                flags <= 12'h000;
            end else begin
                case (state)
                    S_IDLE: state <= S_PICK;
                    S_PICK: begin
                        if (range_bits[2*adc_channel +: 2] != `RANGE_OFF) begin
                            adc_start <= 1'b1;
                            conv_cnt <= 16'h0000;
                            state <= S_CONV;
                        end else begin
                            adc_channel <= (adc_channel == 4'hb) ? 4'h0 : adc_channel + 4'h1;
                        end
                    end
                    S_CONV: begin
                        conv_cnt <= conv_cnt + 16'h0001;
                        if (adc_done) begin
                            res_we <= 1'b1;
                            res_data <= adc_result;
                            state <= S_WAIT;
                        end else if (conv_cnt == CONV_MAX - 16'h0001) begin
                            adc_channel <= (adc_channel == 4'hb) ? 4'h0 : adc_channel + 4'h1;
                            state <= S_PICK;
                        end
                    end
                    S_WAIT: state <= S_CMP;
                    S_CMP: begin
                        flags[adc_channel] <= viol[adc_channel] & monitored[adc_channel];
                        adc_channel <= (adc_channel == 4'hb) ? 4'h0 : adc_channel + 4'h1;
                        state <= S_PICK;
                    end
                    default: state <= S_IDLE;
                endcase
            end
        end
    end

    // Logging copies the record into 00h-0Eh, then protects it until the next power-on clear.
    always @(posedge sys_clk) begin
        if (reset) begin
            logging <= 1'b0;
            log_lock <= 1'b0;
            log_idx <= 4'h0;
        end else if (logging) begin
            log_idx <= log_idx + 4'h1;
            if (log_idx == `NV_LOG_LAST) begin
                logging <= 1'b0;
                log_lock <= 1'b1;
            end
        end else if (run && !log_lock && |(flags & fault_en & log_en)) begin
            logging <= 1'b1;
            log_idx <= 4'h0;
        end
    end

    always @(posedge sys_clk) begin
        if (reset) begin
            fault_latched <= 1'b0;
            seq_out <= 12'h000;
            fault_out <= 1'b0;
            monitor_run <= 1'b0;
            boot_busy <= 1'b1;
        end else begin
            if (!run) begin
                fault_latched <= 1'b0;
            end else if (fault_now && fault_mode[`FAULT_MODE_LATCH]) begin
                fault_latched <= 1'b1;
            end
            seq_out <= {12{run & ~fault_now & ~fault_latched}} & seq_asg;
            fault_out <= fault_now;
            monitor_run <= run;
            boot_busy <= booting;
        end
    end

    always @(posedge sys_clk) begin
        if (reset) begin
            seq_oe <= 12'h000;
            trim_oe <= 12'h000;
            gpio_oe <= 6'h00;
        end else begin
            seq_oe <= booting ? 12'h000 : 12'hfff;
            trim_oe <= booting ? 12'h000 : trim_en;
            gpio_oe <= booting ? 6'h00 : gpio_dir;
        end
    end

    // The hold count restarts whenever an input with a sequence position is flagged outside its window.
    always @(posedge sys_clk) begin
        if (reset || booting || |flags) begin
            hold_cnt <= 16'h0000;
            reset_out_n <= 1'b0;
        end else if (hold_cnt == RESET_HOLD_CYC - 16'h0001) begin
            reset_out_n <= 1'b1;
        end else begin
            hold_cnt <= hold_cnt + 16'h0001;
        end
    end

    always @(posedge sys_clk) begin
        if (reset) begin
            trim_en <= 12'h000;
            gpio_dir <= 6'h00;
        end else if (acc_fire && acc_write && page_sel == `PAGE_EXTENDED) begin
            case (acc_addr)
                `EXT_GPIO_DIR: gpio_dir <= acc_wdata[5:0];
                `EXT_TRIM_EN_LO: trim_en[7:0] <= acc_wdata;
                `EXT_TRIM_EN_HI: trim_en[11:8] <= acc_wdata[3:0];
                default: gpio_dir <= gpio_dir;
            endcase
        end
    end

    always @* begin
        ext_byte = 8'h00;
        if (rd_addr <= `EXT_RESULT_LAST) begin
            if (rd_addr[0]) begin
                ext_byte = {res_flat[rd_addr[4:1]*10 +: 2], 6'h00};
            end else begin
                ext_byte = res_flat[rd_addr[4:1]*10+2 +: 8];
            end
        end else begin
            case (rd_addr)
                `EXT_FLAGS_LO: ext_byte = flags[7:0];
                `EXT_FLAGS_HI: ext_byte = {4'h0, flags[11:8]};
                `EXT_GPIO_DIR: ext_byte = {2'h0, gpio_dir};
                `EXT_TRIM_EN_LO: ext_byte = trim_en[7:0];
                `EXT_TRIM_EN_HI: ext_byte = {4'h0, trim_en[11:8]};
                default: ext_byte = 8'h00;
            endcase
        end
        case (rd_page)
            `PAGE_DEFAULT: next_rdata = rd_addr[7] ? 8'h00 :
                (rd_addr[6:0] == `DP_ENABLE_MARGIN_CONTROL) ? ctrl : dp_rdata;
            `PAGE_NONVOL: next_rdata = nv_rdata;
            default: next_rdata = ext_byte;
        endcase
    end

    always @(posedge sys_clk) begin
        if (reset) begin
            rd_pend <= 1'b0;
            rd_page <= `PAGE_DEFAULT;
            rd_addr <= 8'h00;
            acc_rdata <= 8'h00;
            acc_rvalid <= 1'b0;
        end else begin
            rd_pend <= acc_fire & ~acc_write;
            if (acc_fire) begin
                rd_page <= page_sel;
                rd_addr <= acc_addr;
            end
            acc_rvalid <= rd_pend;
            if (rd_pend) begin
                acc_rdata <= next_rdata;
            end
        end
    end
endmodule // supply_monitor_scan_boot_core
`default_nettype wire

/* shared/supply_core_regs.vh */
// Constants of the supply monitor core: offsets, fields, reset values, commands and timing.
`ifndef SUPPLY_CORE_REGS_VH
`define SUPPLY_CORE_REGS_VH

// Timing counts in 25 ns core clock cycles: 8.3 us, 1.5 ms and 1 ms, sized to their counters.
`define CONV_MAX_CYC 16'h014c
`define BOOT_MAX_CYC 17'h0ea60
`define RESET_HOLD_CYC 16'h9c40

`define PAGE_DEFAULT 2'h0
`define PAGE_EXTENDED 2'h1
`define PAGE_NONVOL 2'h2

`define CMD_I2C_EXT_ON 8'h98
`define CMD_I2C_EXT_OFF 8'h99
`define CMD_I2C_NV_ON 8'h9a
`define CMD_I2C_NV_OFF 8'h9b
`define CMD_JTAG_EXT_ON 8'h09
`define CMD_JTAG_EXT_OFF 8'h0a
`define CMD_JTAG_NV_ON 8'h0b
`define CMD_JTAG_NV_OFF 8'h0c

`define DP_DAC_LAST 7'h0b
`define DP_COPY_FIRST 7'h0f
`define DP_COPY_LAST 7'h7d
`define DP_RANGE0 7'h0f
`define DP_RANGE1 7'h10
`define DP_RANGE2 7'h11
`define DP_OV_BASE 7'h23
`define DP_UV_BASE 7'h2f
`define DP_FAULT_MODE 7'h47
`define DP_FAULT_EN_LO 7'h48
`define DP_FAULT_EN_HI 7'h49
`define DP_LOG_EN_LO 7'h4a
`define DP_LOG_EN_HI 7'h4b
`define DP_ENABLE_MARGIN_CONTROL 7'h4d
`define DP_SEQ_ASSIGN_LO 7'h5e
`define DP_SEQ_ASSIGN_HI 7'h5f

`define CTRL_SW_DISABLE 0
`define CTRL_MARGIN_EN 1
`define CTRL_EARLY_OV 2
`define CTRL_WDOG_INDEP 3
`define FAULT_MODE_LATCH 0

`define EXT_RESULT_LAST 8'h17
`define EXT_FLAGS_LO 8'h18
`define EXT_FLAGS_HI 8'h19
`define EXT_GPIO_DIR 8'h1b
`define EXT_TRIM_EN_LO 8'h1c
`define EXT_TRIM_EN_HI 8'h1d

`define NV_LOG_LAST 8'h0e
`define NV_LOG_FLAGS_LO 4'hc
`define NV_LOG_FLAGS_HI 4'hd
`define NV_LOG_MARK 8'h01

`define RANGE_OFF 2'h3
`define RESET_BYTE 8'h00

`endif

/* test/adc_model.sv */
// Behavioural converter that answers each start after a chosen delay.
`timescale 1ns/1ps
`default_nettype none
module adc_model (
    input wire logic sys_clk, // Core clock.
    input wire logic adc_start, // Start pulse.
    input wire logic [3:0] adc_channel, // Selected input.
    input wire logic [8:0] delay, // Cycles from start to done.
    output logic adc_done = 1'b0, // Done pulse.
    output logic [9:0] adc_result = 10'h0 // Result, valid with done.
);
    logic [8:0] cnt = 9'h0;
    always @(posedge sys_clk) begin
        adc_done <= 1'b0;
        // Outside a done pulse the bus toggles, so a stale result is never mistaken for fresh.
        adc_result <= ~adc_result;
        if (adc_start) begin
            cnt <= delay;
        end else if (cnt != 9'h0) begin
            cnt <= cnt - 9'h1;
            if (cnt == 9'h1) begin
                adc_done <= 1'b1;
                adc_result <= {2'b10, adc_channel, 4'h5};
            end
        end
    end
endmodule // adc_model
`default_nettype wire

/* test/supply_core_properties.sv */
// Concurrent checks on the ports of the supply monitor core.
`timescale 1ns/1ps
`default_nettype none
module supply_core_properties (
    input wire logic sys_clk, // Core clock.
    input wire logic reset, // Synchronous reset.
    input wire logic acc_valid, // Register request.
    input wire logic acc_write, // Write flag.
    input wire logic acc_ready, // Request accepted.
    input wire logic acc_rvalid, // Read answer.
    input wire logic page_cmd_valid, // Page command strobe.
    input wire logic page_cmd_jtag, // Command source.
    input wire logic [7:0] page_cmd_code, // Command code.
    input wire logic [1:0] page_sel, // Selected page.
    input wire logic adc_start, // Conversion start.
    input wire logic boot_busy, // Boot in progress.
    input wire logic monitor_run, // Monitoring active.
    input wire logic reset_out_n, // Reset output.
    input wire logic fault_out, // Fault output.
    input wire logic [11:0] seq_oe, // Sequenced enables.
    input wire logic [11:0] trim_oe, // Trim enables.
    input wire logic [5:0] gpio_oe // Pin enables.
);
    default clocking @(posedge sys_clk); endclocking
    default disable iff (reset);
    chk_boot_no_access: assert property (boot_busy |-> !acc_ready)
        else $error("request accepted during boot");
    chk_boot_reset_low: assert property (boot_busy |-> !reset_out_n)
        else $error("reset output released during boot");
    chk_boot_high_z: assert property (boot_busy |-> (seq_oe | trim_oe) == 12'h0 && !gpio_oe)
        else $error("output driven during boot");
    chk_boot_bounded: assert property ($fell(reset) |-> ##[1:1000] !boot_busy)
        else $error("boot did not finish");
    chk_boot_masked: assert property (boot_busy |-> !fault_out && !monitor_run)
        else $error("fault or run during boot");
    chk_read_answer: assert property (acc_valid && acc_ready && !acc_write |-> ##2 acc_rvalid)
        else $error("read answer missing");
    chk_page_ext: assert property (page_cmd_valid && !boot_busy && !page_cmd_jtag
        && page_cmd_code == 8'h98 |=> page_sel == 2'h1) else $error("extended page not selected");
    chk_page_nv: assert property (page_cmd_valid && !boot_busy && page_cmd_jtag
        && page_cmd_code == 8'h0b |=> page_sel == 2'h2) else $error("nonvolatile page not selected");
    cover property (acc_rvalid);
    cover property (adc_start);
    cover property ($rose(fault_out));
endmodule // supply_core_properties
bind supply_monitor_scan_boot_core supply_core_properties u_props (.sys_clk, .reset, .acc_valid,
    .acc_write, .acc_ready, .acc_rvalid, .page_cmd_valid, .page_cmd_jtag, .page_cmd_code,
    .page_sel, .adc_start, .boot_busy, .monitor_run, .reset_out_n, .fault_out, .seq_oe,
    .trim_oe, .gpio_oe);
`default_nettype wire

/* test/testbench.sv */
// Self-checking bench for the supply monitor core.
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, e, g) begin n_checks++; if ((g) !== (e)) begin mismatches++; $display("unexpected %s expected %h seen %h", nm, e, g); end end
`define WAIT(c, n) begin i = 0; while (!(c) && i < n) begin @(negedge sys_clk); i++; end end
module testbench;
    logic sys_clk = 0, reset = 1, en_pin = 1, acc_valid = 0, acc_write = 0, page_cmd_valid = 0;
    logic page_cmd_jtag = 0, acc_ready, acc_rvalid, adc_start, adc_done, boot_busy;
    logic monitor_run, reset_out_n, fault_out;
    logic [7:0] acc_addr = 0, acc_wdata = 0, page_cmd_code = 0, acc_rdata, rd;
    logic [1:0] page_sel;
    logic [3:0] adc_channel;
    logic [9:0] adc_result;
    logic [11:0] seq_out, seq_oe, trim_oe;
    logic [5:0] gpio_oe;
    logic [8:0] delay = 9'h3;
    int mismatches = 0, n_checks = 0, cycles = 0, i;
    // Packed as {jtag, code, expected page}.
    logic [10:0] ptab [8] = '{11'h261, 11'h264, 11'h26a, 11'h26c, 11'h425, 11'h428, 11'h42e, 11'h430};
    localparam logic [9:0] CONV0 = 10'h205;
    supply_monitor_scan_boot_core #(.RESET_HOLD_CYC(16'h0014)) dut (.sys_clk, .reset, .en_pin,
        .acc_valid, .acc_write, .acc_addr, .acc_wdata, .acc_ready, .acc_rdata, .acc_rvalid,
        .page_cmd_valid, .page_cmd_jtag, .page_cmd_code, .page_sel, .adc_channel, .adc_start,
        .adc_done, .adc_result, .boot_busy, .monitor_run, .reset_out_n, .fault_out, .seq_out,
        .seq_oe, .trim_oe, .gpio_oe);
    adc_model u_adc (.sys_clk, .adc_start, .adc_channel, .delay, .adc_done, .adc_result);
    initial begin
        forever #12.5 sys_clk = ~sys_clk;
    end
    task automatic end_of_test();
        $display("checks %0d mismatches %0d", n_checks, mismatches);
        if (mismatches == 0 && n_checks > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask
    always @(posedge sys_clk) begin
        cycles++;
        if (cycles == 20000) begin
            mismatches++;
            end_of_test();
        end
    end
    task automatic acc(input logic w, input logic [7:0] a, input logic [7:0] d);
        @(negedge sys_clk);
        acc_valid = 1'b1;
        acc_write = w;
        acc_addr = a;
        acc_wdata = d;
        `WAIT(acc_ready === 1'b1, 300)
        @(negedge sys_clk);
        acc_valid = 1'b0;
        `WAIT(w || acc_rvalid === 1'b1, 4)
        rd = acc_rdata;
    endtask
    task automatic pcmd(input logic j, input logic [7:0] c);
        @(negedge sys_clk);
        page_cmd_valid = 1'b1;
        page_cmd_jtag = j;
        page_cmd_code = c;
        @(negedge sys_clk);
        page_cmd_valid = 1'b0;
    endtask
    initial begin
        repeat (20) @(negedge sys_clk);
        reset = 0;
        @(negedge sys_clk);
        `CHK("acc_ready", 1'b0, acc_ready)
        `CHK("seq_oe", 12'h0, seq_oe)
        `WAIT(boot_busy === 1'b0, 1000)
        `CHK("page_sel", 2'h0, page_sel)
        acc(0, 8'h00, 0); `CHK("trim code", 8'h00, rd)
        acc(0, 8'h4d, 0); `CHK("control", 8'h00, rd)
        acc(1, 8'h4d, 8'hf2); acc(0, 8'h4d, 0); `CHK("control", 8'h02, rd)
        acc(1, 8'h80, 8'h5a); acc(0, 8'h80, 0); `CHK("unmapped", 8'h00, rd)
        for (int k = 0; k < 8; k++) begin
            pcmd(ptab[k][10], ptab[k][9:2]); `CHK("page_sel", ptab[k][1:0], page_sel)
        end
        // Only input 0 stays enabled, and the converter answers slowly.
        acc(1, 8'h0f, 8'hfc); acc(1, 8'h10, 8'hff); acc(1, 8'h11, 8'hff);
        delay = 9'h096;
        @(negedge sys_clk);
        for (int k = 0; k < 4; k++) begin
            `WAIT(adc_start === 1'b1, 500)
            `CHK("adc_channel", 4'h0, adc_channel)
            @(negedge sys_clk);
        end
        delay = 9'h3;
        `CHK("reset_out_n", 1'b1, reset_out_n)
        pcmd(0, 8'h98);
        acc(0, 8'h00, 0); `CHK("result msb", CONV0[9:2], rd)
        acc(0, 8'h01, 0); `CHK("result lsb", {CONV0[1:0], 6'h0}, rd)
        acc(1, 8'h1b, 8'h2a); acc(0, 8'h1b, 0); `CHK("gpio dir", 8'h2a, rd)
        `CHK("gpio_oe", 6'h2a, gpio_oe)
        pcmd(0, 8'h99);
        acc(1, 8'h2f, 8'hff); acc(1, 8'h48, 8'h01);
        repeat (100) @(negedge sys_clk);
        `CHK("fault_out", 1'b0, fault_out)
        acc(1, 8'h5e, 8'h01);
        `WAIT(fault_out === 1'b1, 500)
        `CHK("fault_out", 1'b1, fault_out)
        `CHK("seq_out", 12'h000, seq_out)
        acc(1, 8'h4a, 8'h01); pcmd(0, 8'h9a);
        acc(1, 8'h0e, 8'h55); acc(0, 8'h0e, 0); `CHK("log mark", 8'h01, rd)
        acc(0, 8'h00, 0); `CHK("log msb", CONV0[9:2], rd)
        en_pin = 0;
        repeat (8) @(negedge sys_clk);
        `CHK("monitor_run", 1'b0, monitor_run)
        end_of_test();
    end
endmodule // testbench
`default_nettype wire
